// >>> rtl/nvm_access_pkg.sv
/*
 * constants for the data nonvolatile access controller: i/o offsets,
 * control bit positions, stall and timing counts.
 * assumes a single 50 MHz core clock and an internal 1 MHz timing tick.
 */
package nvm_access_pkg;
   // i/o space offsets (port instructions); data space adds the bias
   localparam logic [6:0] io_addr_low   = 7'h1e;
   localparam logic [6:0] io_addr_high  = 7'h1f;
   localparam logic [6:0] io_data       = 7'h1d;
   localparam logic [6:0] io_control    = 7'h1c;
   localparam logic [6:0] io_busy       = 7'h37;
   localparam logic [6:0] data_bias     = 7'h20;
   localparam logic [6:0] bit_io_limit  = 7'h1f;
   // control register bit positions
   localparam int bit_read      = 0;
   localparam int bit_write     = 1;
   localparam int bit_arm       = 2;
   localparam int bit_irq_en    = 3;
   localparam int bit_spm       = 0;
   localparam logic [7:0] control_reset = 8'h00;
   // address width and cell count
   localparam int addr_w = 9;
   localparam int cells  = 512;
   // arm window and cpu stall counts
   localparam logic [2:0] arm_window    = 3'h4;
   localparam logic [2:0] stall_write   = 3'h2;
   localparam logic [2:0] stall_read    = 3'h4;
   // write timing: 8448 ticks of a 1 MHz oscillator
   localparam int rc_freq_hz     = 1000000;
   localparam int clk_freq_hz    = 50000000;
   localparam int write_rc_ticks = 8448;
   localparam int rc_div         = clk_freq_hz / rc_freq_hz;
   localparam logic [5:0]  rc_div_last     = 6'(rc_div - 1);
   localparam logic [13:0] write_ticks_last = 14'(write_rc_ticks - 1);
endpackage

// >>> rtl/nvm_io_if.sv
/*
 * i/o register bus between the cpu core and the nvm access controller.
 * assumes both ends share ref_clk; strobes last one cycle.
 */
`timescale 1ns/1ps
interface nvm_io_if;
   logic       io_wr;      // write strobe, one cycle
   logic       io_rd;      // read strobe, one cycle
   logic       io_bitop;   // write comes from bit set / bit clear
   logic [6:0] io_addr;    // i/o or data-space address
   logic [7:0] io_wdata;
   logic [7:0] io_rdata;   // valid the cycle after io_rd
   logic       cpu_stall;  // holds off the next instruction
   logic       ready_irq;  // ready interrupt level
   logic       global_ie;  // global interrupt enable from the core
   modport device (input io_wr, io_rd, io_bitop, io_addr, io_wdata, global_ie,
                   output io_rdata, cpu_stall, ready_irq);
   modport core   (output io_wr, io_rd, io_bitop, io_addr, io_wdata, global_ie,
                   input io_rdata, cpu_stall, ready_irq);
endinterface

// >>> rtl/nvm_down_counter.sv
/*
 * loadable down counter with terminal flag.
 * assumes load and enable come from the same clock domain.
 */
`timescale 1ns/1ps
module nvm_down_counter #(
   parameter int w = 8
) (
   input  wire logic         ref_clk,
   input  wire logic         rstn,
   input  wire logic         load,
   input  wire logic [w-1:0] load_val,
   input  wire logic         en,
   output logic              zero,
   output logic [w-1:0]      count
);
   logic [w-1:0] next_count;

   // load wins over counting; stop at zero
   always_comb begin
      next_count = count;
      if (load) begin
         next_count = load_val;
      end else if (en && count != '0) begin
         next_count = count - w'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   assign zero = (count == '0);
endmodule

// >>> rtl/nvm_access_ctrl.sv
/*
 * device end: control, address and data registers for cpu access to the
 * 512-byte data nonvolatile array, self-timed write, cpu stall.
 * assumes the array is modelled here as a register array and the flash
 * self-program busy level comes in on the same clock.
 */
`timescale 1ns/1ps
// Functional notes
// [RULE_01] write only when strobe set while armed
// [RULE_02] strobe honoured within four cycles of arm
// [RULE_03] software follows poll, load, arm, strobe order
// [RULE_04] write strobe held until write time elapses
// [RULE_05] write strobe stalls cpu two cycles
// [RULE_06] read strobe loads data register at once
// [RULE_07] read strobe stalls cpu four cycles
// [RULE_08] busy write blocks reads and address changes
// [RULE_09] no write starts while flash programming
// [RULE_10] write lasts 8448 ticks of 1 MHz
// [RULE_11] late strobe after arm expiry fails write
// [RULE_12] write continues through power-down; oscillator runs
// [RULE_13] reset does not abort a running write
// [RULE_14] io address plus 0x20 maps data space
// [RULE_15] write-one-to-clear flags clear on bit ops
// [RULE_16] arm bit self-clears four cycles after set
// [RULE_17] ready irq while enabled and strobe clear
// [RULE_18] nine-bit address, upper bits read zero
// [RULE_19] read strobe reads back as zero
// [RULE_20] reset clears control bits except running write
module nvm_access_ctrl #(
   parameter int rc_div = nvm_access_pkg::rc_div  // core clocks per timing tick
) (
   input  wire logic ref_clk,
   input  wire logic rstn,
   input  wire logic power_rstn,
   input  wire logic self_program_busy,
   input  wire logic sleep_powerdown,
   output logic      osc_running,
   nvm_io_if.device  bus
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0] cells_mem [nvm_access_pkg::cells];
   logic [nvm_access_pkg::addr_w-1:0] cell_address_reg, next_cell_address_reg;
   logic [7:0]  cell_data_reg, next_cell_data_reg;
   logic        ready_irq_enable, next_ready_irq_enable;
   logic        write_strobe_bit, next_write_strobe_bit;
   logic [7:0]  rdata, next_rdata;
   logic        stall, next_stall;
   logic        irq, next_irq;
   logic [8:0]  wr_addr;
   logic [7:0]  wr_data;
   logic        start_write;
   logic        do_read;
   logic        arm_live;
   logic [2:0]  arm_count;
   logic [2:0]  stall_count;
   logic [5:0]  div_count, next_div_count;
   logic [13:0] tick_count;
   logic        tick;
   logic        hit_ctrl, hit_al, hit_ah, hit_data;
   logic [6:0]  io_a;
   logic        next_osc_running;
   // a smaller divider only shortens simulation; hardware keeps the default
   localparam logic [5:0] div_last = 6'(rc_div - 1);

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   // port access uses the bare offset, data-space access adds the bias
   always_comb begin
      io_a = (bus.io_addr >= nvm_access_pkg::data_bias) ?
             bus.io_addr - nvm_access_pkg::data_bias : bus.io_addr; // RULE_14
   end
   assign hit_ctrl = bus.io_wr && io_a == nvm_access_pkg::io_control;
   assign hit_al   = bus.io_wr && io_a == nvm_access_pkg::io_addr_low;
   assign hit_ah   = bus.io_wr && io_a == nvm_access_pkg::io_addr_high;
   assign hit_data = bus.io_wr && io_a == nvm_access_pkg::io_data;

   // strobe needs live arm and flash idle; arm counter doubles as window
   assign arm_live    = (arm_count != 3'h0);
   assign start_write = hit_ctrl && bus.io_wdata[nvm_access_pkg::bit_write] && arm_live
                        && !write_strobe_bit && !self_program_busy; // RULE_01 RULE_02 RULE_09 RULE_11
   // read strobe is a pulse; nothing holds it, so it reads back zero
   // no write-one-to-clear bits here, so a bit-op write-back is harmless
   assign do_read = hit_ctrl && bus.io_wdata[nvm_access_pkg::bit_read]
                    && !write_strobe_bit; // RULE_06 RULE_08 RULE_19 RULE_15

   // ----------------------------------------------------------------
   // arm window and stall counters
   // ----------------------------------------------------------------
   // arm reloads on a write of one unless a write starts; cleared four cycles later, or at once when a write starts
   nvm_down_counter #(.w(3)) u_arm (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .load     (hit_ctrl && (bus.io_wdata[nvm_access_pkg::bit_arm] || start_write)),
      .load_val (start_write ? 3'h0 : nvm_access_pkg::arm_window), // RULE_16
      .en       (1'b1),
      .zero     (),
      .count    (arm_count)
   );

   nvm_down_counter #(.w(3)) u_stall (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .load     (start_write || do_read),
      .load_val (do_read ? nvm_access_pkg::stall_read
                         : nvm_access_pkg::stall_write), // RULE_05 RULE_07
      .en       (1'b1),
      .zero     (),
      .count    (stall_count)
   );

   // ----------------------------------------------------------------
   // write timer, on power-on reset only so system reset spares it
   // ----------------------------------------------------------------
   // the 1 MHz tick keeps running while busy even in power-down sleep
   assign tick = write_strobe_bit && (div_count == div_last);

   always_comb begin
      next_div_count = 6'h00;
      if (write_strobe_bit && !tick) begin
         next_div_count = div_count + 6'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge power_rstn) begin
      if (!power_rstn) begin
         div_count <= 6'h00;
      end else begin
         div_count <= next_div_count; // RULE_12 RULE_13
      end
   end

   nvm_down_counter #(.w(14)) u_timer (
      .ref_clk  (ref_clk),
      .rstn     (power_rstn),
      .load     (start_write),
      .load_val (nvm_access_pkg::write_ticks_last), // RULE_10
      .en       (tick),
      .zero     (),
      .count    (tick_count)
   );

   // busy bit: set on start, hardware clear when the last tick ends
   always_comb begin
      next_write_strobe_bit = write_strobe_bit;
      next_osc_running      = write_strobe_bit || (osc_running && sleep_powerdown);
      if (start_write) begin
         next_write_strobe_bit = 1'b1;
      end else if (tick && tick_count == 14'h0000) begin
         next_write_strobe_bit = 1'b0; // RULE_04
      end
   end

   always_ff @(posedge ref_clk or negedge power_rstn) begin
      if (!power_rstn) begin
         write_strobe_bit <= 1'b0;
      end else begin
         write_strobe_bit <= next_write_strobe_bit; // RULE_13 RULE_20
      end
   end

   // oscillator stays on during and after a write begun before sleep
   always_ff @(posedge ref_clk or negedge power_rstn) begin
      if (!power_rstn) begin
         osc_running <= 1'b0;
      end else begin
         osc_running <= next_osc_running; // RULE_12
      end
   end

   // commit the byte: latched at start so later loads cannot corrupt it
   always_ff @(posedge ref_clk) begin
      if (start_write) begin
         wr_addr <= cell_address_reg;
         wr_data <= cell_data_reg;
      end
      if (write_strobe_bit && tick && tick_count == 14'h0000) begin
         cells_mem[wr_addr] <= wr_data;
      end
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   always_comb begin
      next_cell_address_reg = cell_address_reg;
      next_cell_data_reg    = cell_data_reg;
      next_ready_irq_enable = ready_irq_enable;
      if (!write_strobe_bit && hit_al) begin
         next_cell_address_reg[7:0] = bus.io_wdata; // RULE_08
      end
      if (!write_strobe_bit && hit_ah) begin
         next_cell_address_reg[8] = bus.io_wdata[0]; // RULE_18
      end
      if (hit_data) begin
         next_cell_data_reg = bus.io_wdata;
      end
      if (do_read) begin
         next_cell_data_reg = cells_mem[cell_address_reg]; // RULE_06
      end
      if (hit_ctrl) begin
         next_ready_irq_enable = bus.io_wdata[nvm_access_pkg::bit_irq_en];
      end
   end

   // read mux; reserved bits and upper address read zero
   always_comb begin
      next_rdata = 8'h00;
      unique case (io_a)
         nvm_access_pkg::io_control: begin
            next_rdata = {4'h0, ready_irq_enable, arm_live, write_strobe_bit, 1'b0};
         end
         nvm_access_pkg::io_addr_low:  next_rdata = cell_address_reg[7:0];
         nvm_access_pkg::io_addr_high: next_rdata = {7'h00, cell_address_reg[8]}; // RULE_18
         nvm_access_pkg::io_data:      next_rdata = cell_data_reg;
         default:                      next_rdata = 8'h00;
      endcase
      next_stall = (stall_count > 3'h1) || start_write || do_read;
      next_irq   = ready_irq_enable && bus.global_ie && !next_write_strobe_bit; // RULE_17
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cell_address_reg <= '0;
         cell_data_reg    <= 8'h00;
         ready_irq_enable <= 1'b0; // RULE_20
         rdata            <= 8'h00;
         stall            <= 1'b0;
         irq              <= 1'b0;
      end else begin
         cell_address_reg <= next_cell_address_reg;
         cell_data_reg    <= next_cell_data_reg;
         ready_irq_enable <= next_ready_irq_enable;
         rdata            <= next_rdata;
         stall            <= next_stall;
         irq              <= next_irq;
      end
   end

   assign bus.io_rdata  = rdata;
   assign bus.cpu_stall = stall;
   assign bus.ready_irq = irq;
endmodule

// >>> rtl/nvm_core_port.sv
/*
 * core end: turns simple user requests into i/o strobes toward the nvm
 * controller and honours its stall.
 * assumes the user keeps interrupts off across the arm-strobe pair and
 * checks flash busy before asking for a write.
 */
`timescale 1ns/1ps
module nvm_core_port (
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic       req_wr,
   input  wire logic       req_rd,
   input  wire logic       req_bitop,
   input  wire logic [6:0] req_addr,
   input  wire logic [7:0] req_wdata,
   input  wire logic       int_enable,
   output logic            req_ready,
   output logic [7:0]      rsp_data,
   output logic            rsp_valid,
   output logic            irq_seen,
   nvm_io_if.core          bus
);
   logic       wr, next_wr;
   logic       rd, next_rd;
   logic       bitop, next_bitop;
   logic [6:0] addr, next_addr;
   logic [7:0] wdata, next_wdata;
   logic       rd_wait, next_rd_wait;
   logic       ready, next_ready;

   // ----------------------------------------------------------------
   // request issue
   // ----------------------------------------------------------------
   // one request per free cycle; stall from the device holds the queue
   // stay busy the cycle after an issue: the stall it causes is not seen yet
   always_comb begin
      next_wr      = 1'b0;
      next_rd      = 1'b0;
      next_bitop   = 1'b0;
      next_addr    = addr;
      next_wdata   = wdata;
      next_rd_wait = rd;
      next_ready   = !bus.cpu_stall && !wr && !rd;
      if (ready && !bus.cpu_stall && (req_wr || req_rd)) begin
         next_wr    = req_wr;
         next_rd    = req_rd && !req_wr;
         next_bitop = req_bitop;
         next_addr  = req_addr;
         next_wdata = req_wdata;
         next_ready = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wr        <= 1'b0;
         rd        <= 1'b0;
         bitop     <= 1'b0;
         addr      <= 7'h00;
         wdata     <= 8'h00;
         rd_wait   <= 1'b0;
         ready     <= 1'b0;
         rsp_data  <= 8'h00;
         rsp_valid <= 1'b0;
         irq_seen  <= 1'b0;
      end else begin
         wr        <= next_wr;
         rd        <= next_rd;
         bitop     <= next_bitop;
         addr      <= next_addr;
         wdata     <= next_wdata;
         rd_wait   <= next_rd_wait;
         ready     <= next_ready;
         rsp_data  <= bus.io_rdata;
         rsp_valid <= rd_wait;
         irq_seen  <= bus.ready_irq;
      end
   end

   assign req_ready    = ready;
   assign bus.io_wr    = wr;
   assign bus.io_rd    = rd;
   assign bus.io_bitop = bitop;
   assign bus.io_addr  = addr;
   assign bus.io_wdata = wdata;
   assign bus.global_ie = int_enable;
endmodule

// >>> dv/nvm_access_props.sv
/*
 * checker for the nvm i/o bus between core port and controller.
 * assumes one ref_clk domain; inputs are the nvm_io_if signals.
 */
`timescale 1ns/1ps
module nvm_access_props #(
   parameter int rc_div = nvm_access_pkg::rc_div  // core clocks per timing tick
) (
   input wire logic       ref_clk,
   input wire logic       rstn,
   input wire logic       power_rstn,
   input wire logic       self_program_busy,
   input wire logic       io_wr,
   input wire logic       io_rd,
   input wire logic       io_bitop,
   input wire logic [6:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic       cpu_stall,
   input wire logic       ready_irq,
   input wire logic       global_ie
);
   // --------
   // helper state
   // --------
   logic        at_ctrl;
   logic        at_high;
   logic        ctrl_wr;
   logic        start;
   logic        irq_on;
   logic [2:0]  arm_cnt;
   logic        irq_en_h;
   logic        busy_h;
   logic [18:0] busy_cnt;
   localparam logic [18:0] busy_stop = 19'(nvm_access_pkg::write_rc_ticks * rc_div - 1);

   // both the port and the data-space alias decode
   assign at_ctrl = io_addr == 7'h1c || io_addr == 7'h3c;
   assign at_high = io_addr == 7'h1f || io_addr == 7'h3f;
   assign ctrl_wr = io_wr && at_ctrl;
   assign start   = ctrl_wr && io_wdata[1] && arm_cnt != 3'h0 && !busy_h && !self_program_busy;
   assign irq_on  = irq_en_h && global_ie && !busy_h;

   // arm window counter and interrupt enable shadow
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         arm_cnt  <= 3'h0;
         irq_en_h <= 1'b0;
      end else begin
         arm_cnt  <= (ctrl_wr && io_wdata[2] && !io_wdata[1]) ? nvm_access_pkg::arm_window
                     : arm_cnt - {2'h0, arm_cnt != 3'h0};
         irq_en_h <= ctrl_wr ? io_wdata[3] : irq_en_h;
      end
   end

   // busy shadow survives system reset and lasts exactly the write time
   always_ff @(posedge ref_clk or negedge power_rstn) begin
      if (!power_rstn) begin
         busy_h   <= 1'b0;
         busy_cnt <= 19'h00000;
      end else if (start) begin
         busy_h   <= 1'b1;
         busy_cnt <= 19'h00000;
      end else if (busy_h) begin
         busy_h   <= busy_cnt < busy_stop;
         busy_cnt <= busy_cnt + 19'h00001;
      end
   end

   // --------
   // assertions
   // --------
   chk_read_stall_four: assert property (@(posedge ref_clk) disable iff (!rstn)
      ctrl_wr && io_wdata[0] && !io_wdata[1] && !busy_h |=> cpu_stall [*4] ##1 !cpu_stall)
      else $error("read strobe stall not four cycles");
   chk_write_stall_two: assert property (@(posedge ref_clk) disable iff (!rstn)
      start && !io_wdata[0] |=> cpu_stall [*2] ##1 !cpu_stall)
      else $error("write strobe stall not two cycles");
   chk_busy_no_read: assert property (@(posedge ref_clk) disable iff (!rstn)
      ctrl_wr && io_wdata[0] && busy_h |=> !cpu_stall)
      else $error("read strobe acted on while busy");
   chk_arm_expired: assert property (@(posedge ref_clk) disable iff (!rstn)
      io_rd && at_ctrl && arm_cnt == 3'h0 |=> !io_rdata[2])
      else $error("arm bit still set after window");
   chk_read_bit_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
      io_rd && at_ctrl |=> !io_rdata[0] && io_rdata[7:4] == 4'h0)
      else $error("read strobe or reserved bits read as one");
   chk_addr_high_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
      io_rd && at_high |=> io_rdata[7:1] == 7'h00)
      else $error("unused address bits read as one");
   chk_busy_readback: assert property (@(posedge ref_clk) disable iff (!rstn)
      io_rd && at_ctrl && busy_h |=> io_rdata[1])
      else $error("write strobe bit dropped during write");
   chk_irq_while_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
      $past(irq_on) && irq_on |-> ready_irq)
      else $error("ready interrupt missing");
   chk_irq_busy_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
      $past(busy_h) && busy_h |-> !ready_irq)
      else $error("ready interrupt during write");
endmodule

// >>> dv/eeprom_access_controller_tb_top.sv
/*
 * bench for the nvm access controller: core port and controller joined
 * by nvm_io_if, driven from the core port user side.
 * assumes one 50 MHz clock; one write runs its full 8448 ticks, with a
 * faster timing tick so that the run stays short.
 */
`timescale 1ns/1ps
module eeprom_access_controller_tb_top;
   localparam int sim_div   = 5;  // core clocks per tick in simulation only
   localparam int wr_cycles = nvm_access_pkg::write_rc_ticks * sim_div;
   typedef struct packed {logic [6:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   logic       ref_clk = 1'b0;
   logic       rstn = 1'b0;
   logic       power_rstn = 1'b0;
   logic       self_program_busy = 1'b0;
   logic       sleep_powerdown = 1'b0;
   logic       osc_running;
   logic       req_wr = 1'b0;
   logic       req_rd = 1'b0;
   logic       req_bitop = 1'b0;
   logic [6:0] req_addr = 7'h00;
   logic [7:0] req_wdata = 8'h00;
   logic       int_enable = 1'b0;
   logic       req_ready;
   logic [7:0] rsp_data;
   logic       rsp_valid;
   logic       irq_seen;
   logic [7:0] q;
   int         failures = 0;
   int         n_compared = 0;
   int         i;
   time        t0;
   row_t       rows [0:7] = '{'{7'h1e, 8'ha5, 8'ha5}, '{7'h3e, 8'h3c, 8'h3c},
      '{7'h1f, 8'hff, 8'h01}, '{7'h3f, 8'h00, 8'h00}, '{7'h1d, 8'h96, 8'h96},
      '{7'h3d, 8'h69, 8'h69}, '{7'h1c, 8'h08, 8'h08}, '{7'h3c, 8'h00, 8'h00}};

   nvm_io_if bus ();
   nvm_access_ctrl #(.rc_div(sim_div)) u_nvm_access_ctrl (.ref_clk(ref_clk), .rstn(rstn),
      .power_rstn(power_rstn),
      .self_program_busy(self_program_busy), .sleep_powerdown(sleep_powerdown),
      .osc_running(osc_running), .bus(bus));
   nvm_core_port u_nvm_core_port (.ref_clk(ref_clk), .rstn(rstn), .req_wr(req_wr),
      .req_rd(req_rd), .req_bitop(req_bitop), .req_addr(req_addr), .req_wdata(req_wdata),
      .int_enable(int_enable), .req_ready(req_ready), .rsp_data(rsp_data),
      .rsp_valid(rsp_valid), .irq_seen(irq_seen), .bus(bus));
   nvm_access_props #(.rc_div(sim_div)) u_nvm_access_props (.ref_clk(ref_clk), .rstn(rstn),
      .power_rstn(power_rstn),
      .self_program_busy(self_program_busy), .io_wr(bus.io_wr), .io_rd(bus.io_rd),
      .io_bitop(bus.io_bitop), .io_addr(bus.io_addr), .io_wdata(bus.io_wdata),
      .io_rdata(bus.io_rdata), .cpu_stall(bus.cpu_stall), .ready_irq(bus.ready_irq),
      .global_ie(bus.global_ie));

   always #10 ref_clk = ~ref_clk;

   // --------
   // shared tasks
   // --------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      if (failures == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // one request, held until the core port takes it; the bound cuts hangs
   task automatic io(input logic w, input logic [6:0] a, input logic [7:0] d);
      int n;
      for (n = 0; req_ready !== 1'b1; n++) begin
         if (n > 100) begin
            failures++;
            stop_test();
         end
         idle(1);
      end
      req_wr = w;
      req_rd = !w;
      req_bitop = w && a < 7'h20;
      req_addr = a;
      req_wdata = d;
      idle(1);
      req_wr = 1'b0;
      req_rd = 1'b0;
      for (n = 0; !w && rsp_valid !== 1'b1; n++) begin
         if (n > 100) begin
            failures++;
            stop_test();
         end
         idle(1);
      end
      q = rsp_data;
      idle(1);
   endtask

   task automatic rdc(input logic [6:0] a, input logic [7:0] e);
      io(1'b0, a, 8'h00);
      check(q, e);
   endtask

   // --------
   // main sequence
   // --------
   initial begin
      idle(20);
      rstn = 1'b1;
      power_rstn = 1'b1;
      for (i = 0; i < 8; i++) begin
         io(1'b1, rows[i].a, rows[i].d);
         rdc(rows[i].a, rows[i].e);
      end
      // flash programming blocks the write start
      self_program_busy = 1'b1;
      io(1'b1, 7'h1c, 8'h04);
      io(1'b1, 7'h1c, 8'h02);
      self_program_busy = 1'b0;
      idle(6);
      rdc(7'h1c, 8'h00);
      // strobe after the arm has lapsed does nothing
      io(1'b1, 7'h3c, 8'h04);
      idle(6);
      io(1'b1, 7'h3c, 8'h02);
      rdc(7'h1c, 8'h00);
      // full write to the top cell with the ready interrupt on
      int_enable = 1'b1;
      io(1'b1, 7'h1f, 8'h01);
      io(1'b1, 7'h1e, 8'hff);
      io(1'b1, 7'h1d, 8'h5a);
      io(1'b1, 7'h1c, 8'h08);
      // enable lands, then the registered irq, then the core's copy of it
      idle(2);
      check({7'h00, irq_seen}, 8'h01);
      io(1'b1, 7'h1c, 8'h0c);
      io(1'b1, 7'h1c, 8'h0a);
      t0 = $time;
      rdc(7'h1c, 8'h0a);
      check({7'h00, irq_seen}, 8'h00);
      io(1'b1, 7'h1e, 8'h00);
      io(1'b1, 7'h1c, 8'h09);
      rdc(7'h1e, 8'hff);
      rdc(7'h1d, 8'h5a);
      rstn = 1'b0;
      idle(2);
      rstn = 1'b1;
      rdc(7'h1c, 8'h02);
      sleep_powerdown = 1'b1;
      io(1'b1, 7'h1c, 8'h08);
      // poll until the write strobe bit drops, as software would
      for (i = 0; q !== 8'h08; i++) begin
         if (i > 200000) begin
            failures++;
            stop_test();
         end
         io(1'b0, 7'h1c, 8'h00);
      end
      i = int'(($time - t0) / 20);
      check({7'h00, i >= wr_cycles && i <= wr_cycles + 20}, 8'h01);
      check({7'h00, osc_running}, 8'h01);
      check({7'h00, irq_seen}, 8'h01);
      sleep_powerdown = 1'b0;
      io(1'b1, 7'h1f, 8'h01);
      io(1'b1, 7'h1e, 8'hff);
      io(1'b1, 7'h1d, 8'h00);
      io(1'b1, 7'h1c, 8'h09);
      rdc(7'h1d, 8'h5a);
      rdc(7'h1c, 8'h08);
      stop_test();
   end
endmodule
